/* rtl/pmr_pkg.sv */
// package of command codes, field layouts and restore values
package pmr_pkg;
   localparam logic [7:0]  CMD_MARGIN_LOW     = 8'hd6;
   localparam logic [7:0]  CMD_PCT_LIMIT      = 8'hd7;
   localparam logic [7:0]  CMD_USER_OPTIONS   = 8'he5;
   localparam logic [15:0] MLO_RESTORE_0      = 16'hfff7;
   localparam logic [15:0] MLO_RESTORE_1      = 16'hfff1;
   localparam logic [15:0] MHI_RESTORE_0      = 16'h0009;
   localparam logic [15:0] MHI_RESTORE_1      = 16'h000f;
   localparam logic [15:0] OPT_RESET          = 16'h1084;
   localparam logic [15:0] OPT_WR_MASK        = 16'h7fff;
   localparam logic [15:0] OPT_NV_MASK        = 16'h7ff7;
   localparam int          OPT_NEGILIM_DIS    = 0;
   localparam int          OPT_RESET_PIN      = 1;
   localparam int          OPT_ADC_EN         = 2;
   localparam int          OPT_FAST_VOUT      = 3;
   localparam int          OPT_MLO_SEL        = 13;
   localparam int          OPT_MHI_SEL        = 14;
   localparam logic signed [7:0] MLO_MIN      = -8'sd64;
   localparam logic signed [7:0] MLO_MAX      = -8'sd1;
   localparam int          VOUT_EXP           = -9;
   localparam int          PG_HYST_OV_PCT     = 105;
   localparam int          PG_HYST_UV_PCT     = 95;
   localparam logic [6:0]  UVF_PCT [4] = '{7'd83, 7'd88, 7'd72, 7'd58};
   localparam logic [6:0]  UVW_PCT [4] = '{7'd88, 7'd90, 7'd78, 7'd64};
   localparam logic [6:0]  OVW_PCT [4] = '{7'd112, 7'd110, 7'd112, 7'd112};
   localparam logic [6:0]  OVF_PCT [4] = '{7'd117, 7'd112, 7'd117, 7'd117};
endpackage : pmr_pkg

/* rtl/pmr_regs.sv */
// margin-low, percent limit and option registers with power-good logic
// How it works
// - loop slave: margin-low and percent limit commands ignored, nacked, fault logged, alert raised
// - margin-low accepts -64..-1 counts of 1.953 mV each
// - out-of-range margin-low clamps, alerts, sets comm and invalid-data bits
// - margin-low operation lowers reference by the margin-low offset
// - reference is command plus trim, further bounded by max and min
// - reference slews at rate chosen by power state
// - voltage values linear, exponent -9, 1/512 V per count
// - margin-low 16-bit, high byte sign copy, only bits 5:0 writable
// - margin-low restores fff7h or fff1h by its restore select bit
// - percent limit one byte, bits 1:0 writable, rest read zero
// - select picks uv warn and ov warn percentages
// - power good drops on ov warn or uv warn crossing
// - power good recovers below 105 or above 95 percent
// - options saved to nonvolatile store on store-all command
// - options bit 0 disables negative current limit on low side switch
// - options bit 1 not decoded, pin always shows power good
// - adc enable cleared stops adc, telemetry holds last values
// - fast measure stops current and temperature, not stored nonvolatile
// - first average after fast-mode change may miss one sample
// - margin-high restores 0009h or 000fh by its restore select bit
`timescale 1ns/1ps
module pmr_regs
   import pmr_pkg::*;
#(
   parameter int REF_W = 16
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rstn,
   input  wire logic                    loop_slave,
   input  wire logic                    cmd_valid,
   input  wire logic                    cmd_write,
   input  wire logic                    cmd_word,
   input  wire logic [7:0]              cmd_code,
   input  wire logic [15:0]             cmd_wdata,
   output logic                         cmd_ack,
   output logic                         cmd_nack,
   output logic [15:0]                  cmd_rdata,
   input  wire logic                    restore_req,
   input  wire logic                    store_req,
   output logic                         nv_write,
   output logic [15:0]                  nv_options,
   input  wire logic [15:0]             nv_options_in,
   output logic                         invalid_command_fault,
   output logic                         invalid_data_fault,
   output logic                         comm_fault_summary,
   output logic                         alert_n,
   input  wire logic                    fault_clear,
   input  wire logic                    margin_low_op,
   input  wire logic [1:0]              power_state,
   input  wire logic [REF_W-1:0]        vout_command,
   input  wire logic [REF_W-1:0]        vout_max,
   input  wire logic [REF_W-1:0]        vout_min,
   input  wire logic signed [REF_W-1:0] trim_offset,
   input  wire logic [REF_W-1:0]        rate_rise,
   input  wire logic [REF_W-1:0]        rate_transition,
   input  wire logic [REF_W-1:0]        rate_fall,
   output logic [REF_W-1:0]             error_amp_reference,
   input  wire logic [REF_W-1:0]        feedback_node,
   output logic                         power_good_out,
   output logic                         reset_pin_n,
   output logic                         neg_current_limit_disable,
   output logic                         adc_enable_bit,
   output logic                         fast_vout_measure,
   output logic                         fast_mode_changed,
   output logic [15:0]                  margin_high_restore
);
   logic [15:0]      margin_low_offset, next_margin_low_offset;
   logic [1:0]       percent_limit_select, next_percent_limit_select;
   logic [15:0]      user_options, next_user_options;
   logic             next_ivc, next_ivd, next_cml, fast_q, next_fast_q;
   logic [REF_W-1:0] next_ref;
   logic             pg_ov, pg_uv, next_pg_ov, next_pg_uv;
   logic             hit_ml, hit_pl, hit_op, mapped;
   logic signed [15:0] wr_word;
   logic             next_power_good, next_reset_pin_n, next_fast_changed;
   logic             next_nv_write;
   logic [15:0]      next_nv_options;
   logic signed [REF_W+1:0] target;
   logic [REF_W+8:0] fb_pct, ref_ovw, ref_uvw, ref_ov_hys, ref_uv_hys;
   logic [REF_W-1:0] step, diff;
   logic [1:0]       sel;

   assign hit_ml = cmd_code == CMD_MARGIN_LOW;
   assign hit_pl = cmd_code == CMD_PCT_LIMIT;
   assign hit_op = cmd_code == CMD_USER_OPTIONS;
   assign mapped = ((hit_ml || hit_pl) && !loop_slave) || hit_op;
   assign cmd_ack  = cmd_valid && mapped;
   assign cmd_nack = cmd_valid && !mapped;
   // byte writes to margin-low zero-extend, so they clamp high
   assign wr_word = cmd_word ? cmd_wdata : {8'h00, cmd_wdata[7:0]};

   // register and fault state
   always_comb begin
      next_margin_low_offset    = margin_low_offset;
      next_percent_limit_select = percent_limit_select;
      next_user_options         = user_options;
      next_ivc = fault_clear ? 1'b0 : invalid_command_fault;
      next_ivd = fault_clear ? 1'b0 : invalid_data_fault;
      next_cml = fault_clear ? 1'b0 : comm_fault_summary;
      // refused command logs its fault even beside a restore
      if (cmd_nack) begin
         next_ivc = 1'b1;
         next_cml = 1'b1;
      end
      if (restore_req) begin
         next_user_options = nv_options_in & OPT_NV_MASK;
         next_margin_low_offset = nv_options_in[OPT_MLO_SEL] ?
            MLO_RESTORE_1 : MLO_RESTORE_0;
      end else if (cmd_ack && cmd_write) begin
         if (hit_ml) begin
            if (wr_word > 16'(MLO_MAX)) begin
               next_margin_low_offset = {{8{1'b1}}, MLO_MAX};
               next_ivd = 1'b1;
               next_cml = 1'b1;
            end else if (wr_word < 16'(MLO_MIN)) begin
               next_margin_low_offset = {{8{1'b1}}, MLO_MIN};
               next_ivd = 1'b1;
               next_cml = 1'b1;
            end else begin
               next_margin_low_offset = {{10{1'b1}}, cmd_wdata[5:0]};
            end
         end
         if (hit_pl)
            next_percent_limit_select = cmd_wdata[1:0];
         if (hit_op && cmd_word)
            next_user_options = cmd_wdata & OPT_WR_MASK;
      end
   end

   always_comb begin
      cmd_rdata = 16'h0000;
      if (hit_ml)
         cmd_rdata = margin_low_offset;
      else if (hit_pl)
         cmd_rdata = {14'h0000, percent_limit_select};
      else if (hit_op)
         cmd_rdata = user_options;
      if (!mapped)
         cmd_rdata = 16'h0000;
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         margin_low_offset     <= MLO_RESTORE_0;
         percent_limit_select  <= 2'b00;
         user_options          <= OPT_RESET;
         invalid_command_fault <= 1'b0;
         invalid_data_fault    <= 1'b0;
         comm_fault_summary    <= 1'b0;
      end else begin
         margin_low_offset     <= next_margin_low_offset;
         percent_limit_select  <= next_percent_limit_select;
         user_options          <= next_user_options;
         invalid_command_fault <= next_ivc;
         invalid_data_fault    <= next_ivd;
         comm_fault_summary    <= next_cml;
      end
   end

   assign alert_n = !(invalid_command_fault || invalid_data_fault);

   // nonvolatile store
   always_comb begin
      next_nv_write   = store_req;
      next_nv_options = nv_options;
      if (store_req)
         next_nv_options = user_options & OPT_NV_MASK;
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         nv_write   <= 1'b0;
         nv_options <= 16'h0000;
      end else begin
         nv_write   <= next_nv_write;
         nv_options <= next_nv_options;
      end
   end

   assign neg_current_limit_disable = user_options[OPT_NEGILIM_DIS];
   assign adc_enable_bit = user_options[OPT_ADC_EN];
   assign fast_vout_measure = user_options[OPT_FAST_VOUT];
   assign margin_high_restore = user_options[OPT_MHI_SEL] ?
      MHI_RESTORE_1 : MHI_RESTORE_0;

   // fast-mode change marks first average as possibly short
   always_comb begin
      next_fast_q       = fast_vout_measure;
      next_fast_changed = fast_q != fast_vout_measure;
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         fast_q            <= 1'b0;
         fast_mode_changed <= 1'b0;
      end else begin
         fast_q            <= next_fast_q;
         fast_mode_changed <= next_fast_changed;
      end
   end

   // reference target and slew, counts of 1/512 V
   always_comb begin
      target = $signed({2'b00, vout_command}) + (REF_W+2)'(trim_offset);
      if (margin_low_op)
         target = target +
            (REF_W+2)'($signed(margin_low_offset));
      if (target > $signed({2'b00, vout_max}))
         target = $signed({2'b00, vout_max});
      if (target < $signed({2'b00, vout_min}))
         target = $signed({2'b00, vout_min});
      unique case (power_state)
         2'd0:    step = rate_rise;
         2'd3:    step = rate_fall;
         default: step = rate_transition;
      endcase
      next_ref = error_amp_reference;
      if (target[REF_W-1:0] > error_amp_reference) begin
         diff = target[REF_W-1:0] - error_amp_reference;
         next_ref = diff > step ? error_amp_reference + step :
                    target[REF_W-1:0];
      end else begin
         diff = error_amp_reference - target[REF_W-1:0];
         next_ref = diff > step ? error_amp_reference - step :
                    target[REF_W-1:0];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn)
         error_amp_reference <= '0;
      else
         error_amp_reference <= next_ref;
   end

   // power good with hysteresis
   always_comb begin
      sel        = percent_limit_select;
      fb_pct     = (REF_W+9)'(feedback_node) * (REF_W+9)'(100);
      ref_ovw    = (REF_W+9)'(error_amp_reference) * (REF_W+9)'(OVW_PCT[sel]);
      ref_uvw    = (REF_W+9)'(error_amp_reference) * (REF_W+9)'(UVW_PCT[sel]);
      ref_ov_hys = (REF_W+9)'(error_amp_reference) *
                   (REF_W+9)'(PG_HYST_OV_PCT);
      ref_uv_hys = (REF_W+9)'(error_amp_reference) *
                   (REF_W+9)'(PG_HYST_UV_PCT);
      next_pg_ov = pg_ov;
      next_pg_uv = pg_uv;
      if (fb_pct > ref_ovw)
         next_pg_ov = 1'b1;
      else if (fb_pct < ref_ov_hys)
         next_pg_ov = 1'b0;
      if (fb_pct < ref_uvw)
         next_pg_uv = 1'b1;
      else if (fb_pct > ref_uv_hys)
         next_pg_uv = 1'b0;
      next_power_good = !(next_pg_ov || next_pg_uv);
      // both pin roles show low while power is not good
      next_reset_pin_n = next_power_good;
   end
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pg_ov          <= 1'b0;
         pg_uv          <= 1'b1;
         power_good_out <= 1'b0;
         reset_pin_n    <= 1'b0;
      end else begin
         pg_ov          <= next_pg_ov;
         pg_uv          <= next_pg_uv;
         power_good_out <= next_power_good;
         reset_pin_n    <= next_reset_pin_n;
      end
   end
endmodule : pmr_regs

/* testbench/pmr_regs_monitor.sv */
// assertion checker for the margin and option register block
`timescale 1ns/1ps
module pmr_regs_monitor
   import pmr_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        loop_slave,
   input wire logic        cmd_valid,
   input wire logic        cmd_write,
   input wire logic        cmd_word,
   input wire logic [7:0]  cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic        cmd_ack,
   input wire logic        cmd_nack,
   input wire logic [15:0] cmd_rdata,
   input wire logic        restore_req,
   input wire logic        store_req,
   input wire logic        nv_write,
   input wire logic [15:0] nv_options,
   input wire logic        invalid_command_fault,
   input wire logic        invalid_data_fault,
   input wire logic        comm_fault_summary,
   input wire logic        alert_n,
   input wire logic        neg_current_limit_disable,
   input wire logic        adc_enable_bit,
   input wire logic        fast_vout_measure,
   input wire logic        fast_mode_changed
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wire rd  = cmd_valid && !cmd_write && cmd_ack;
   wire rml = rd && cmd_code == CMD_MARGIN_LOW;
   wire rpc = rd && cmd_code == CMD_PCT_LIMIT;
   wire slv = cmd_valid && loop_slave
      && (cmd_code == CMD_MARGIN_LOW || cmd_code == CMD_PCT_LIMIT);
   wire bad = cmd_valid && !loop_slave && cmd_write && cmd_word
      && cmd_code == CMD_MARGIN_LOW && cmd_wdata[15:6] != 10'h3ff
      && !restore_req;
   wire opt = cmd_valid && cmd_write && cmd_word && cmd_ack
      && cmd_code == CMD_USER_OPTIONS && !restore_req;
   property p_slave_nack; slv |-> cmd_nack && !cmd_ack; endproperty
   a_slave_nack: assert property (p_slave_nack) else $error("no nack");
   property p_slave_flag;
      slv |=> invalid_command_fault && !alert_n;
   endproperty
   a_slave_flag: assert property (p_slave_flag) else $error("no ivc");
   property p_answer; cmd_valid |-> cmd_ack != cmd_nack; endproperty
   a_answer: assert property (p_answer) else $error("bad answer");
   property p_clamp;
      bad |=> invalid_data_fault && comm_fault_summary && !alert_n;
   endproperty
   a_clamp: assert property (p_clamp) else $error("no clamp flag");
   property p_mlo_rd; rml |-> cmd_rdata[15:6] == 10'h3ff; endproperty
   a_mlo_rd: assert property (p_mlo_rd) else $error("margin range");
   property p_pct_rd; rpc |-> cmd_rdata[7:2] == 6'h00; endproperty
   a_pct_rd: assert property (p_pct_rd) else $error("limit bits");
   property p_opt;
      opt |=> 16'({fast_vout_measure, adc_enable_bit, 1'b0,
         neg_current_limit_disable}) == ($past(cmd_wdata) & 16'h000d);
   endproperty
   a_opt: assert property (p_opt) else $error("option bits");
   property p_store; store_req |=> nv_write && !nv_options[3]; endproperty
   a_store: assert property (p_store) else $error("store");
   property p_fast_chg;
      $changed(fast_vout_measure) |=> fast_mode_changed;
   endproperty
   a_fast_chg: assert property (p_fast_chg) else $error("fast mark");
   c_fast: cover property ($changed(fast_vout_measure));
   c_clamp: cover property (bad);
   c_slave: cover property (slv);
   c_store: cover property (store_req ##1 nv_write);
endmodule : pmr_regs_monitor
bind pmr_regs pmr_regs_monitor mon (.*);

/* testbench/pmr_host_model.sv */
// host model driving one-cycle command transfers
`timescale 1ns/1ps
module pmr_host_model
   import pmr_pkg::*;
(
   input  wire logic        clk_sys,
   output logic             cmd_valid,
   output logic             cmd_write,
   output logic             cmd_word,
   output logic [7:0]       cmd_code,
   output logic [15:0]      cmd_wdata,
   input  wire logic        cmd_ack,
   input  wire logic [15:0] cmd_rdata
);
   initial begin
      {cmd_valid, cmd_write, cmd_word, cmd_code} = 11'h000;
      cmd_wdata = 16'h5a5a;
   end
   task automatic xfer(input logic w, input logic [7:0] c,
      input logic [15:0] d, output logic [15:0] r, output logic a);
      @(negedge clk_sys);
      {cmd_valid, cmd_write, cmd_code, cmd_wdata} = {1'b1, w, c, d};
      cmd_word = c != CMD_PCT_LIMIT;
      @(posedge clk_sys);
      r = cmd_rdata;
      a = cmd_ack;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
      cmd_wdata = ~d;
   endtask : xfer
endmodule : pmr_host_model

/* testbench/pmr_regs_test.sv */
// self-checking bench for the margin and option registers
`timescale 1ns/1ps
module pmr_regs_test;
   import pmr_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rstn, loop_slave, restore_req, store_req, fault_clear;
   logic        margin_low_op, cmd_valid, cmd_write, cmd_word, cmd_ack;
   logic        cmd_nack, nv_write, alert_n, power_good_out, reset_pin_n;
   logic        invalid_command_fault, invalid_data_fault;
   logic        comm_fault_summary, fast_mode_changed, fast_vout_measure;
   logic        neg_current_limit_disable, adc_enable_bit;
   logic [1:0]  power_state;
   logic [7:0]  cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata, nv_options, nv_options_in;
   logic [15:0] vout_command, vout_max, vout_min, trim_offset;
   logic [15:0] rate_rise, rate_transition, rate_fall, feedback_node;
   logic [15:0] error_amp_reference, margin_high_restore;
   int          n_errors = 0;
   int          tests_run = 0;
   int          ov [4] = '{112, 110, 112, 112};
   int          uv [4] = '{88, 90, 78, 64};
   pmr_regs uut (.*);
   pmr_host_model host (.*);
   always #25 clk_sys = ~clk_sys;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [7:0] c,
      input logic [15:0] d, input logic [15:0] e, input logic k);
      logic [15:0] r;
      logic        a;
      host.xfer(w, c, d, r, a);
      chk(16'(a), 16'(k));
      if (!w && k) chk(c == CMD_PCT_LIMIT ? {8'h00, r[7:0]} : r, e);
   endtask : acc
   task automatic pulse(ref logic s);
      @(negedge clk_sys);
      s = 1'b1;
      @(negedge clk_sys);
      s = 1'b0;
   endtask : pulse
   task automatic pg(input int pct, input logic e);
      feedback_node = 16'(512 * pct / 100);
      repeat (6) @(negedge clk_sys);
      chk(16'({power_good_out, reset_pin_n}), 16'({e, e}));
   endtask : pg
   task automatic summarize;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (4000) @(posedge clk_sys);
      n_errors++;
      summarize();
   end
   initial begin
      {rstn, loop_slave, restore_req, store_req, fault_clear} = 5'h00;
      {margin_low_op, power_state, feedback_node} = 19'h0_0000;
      {vout_command, vout_max, vout_min} = {16'h0200, 16'h0300, 16'h0000};
      {rate_rise, rate_transition, rate_fall} = {3{16'h0100}};
      trim_offset = 16'h0000;
      nv_options_in = 16'h0000;
      repeat (10) @(negedge clk_sys);
      rstn = 1'b1;
      power_state = 2'd1;
      acc(1'b0, CMD_MARGIN_LOW, 16'h0000, 16'hfff7, 1'b1);
      acc(1'b0, CMD_PCT_LIMIT, 16'h0000, 16'h0000, 1'b1);
      acc(1'b0, CMD_USER_OPTIONS, 16'h0000, 16'h1084, 1'b1);
      $display("test reset done");
      acc(1'b1, CMD_MARGIN_LOW, 16'hffc5, 16'h0000, 1'b1);
      acc(1'b0, CMD_MARGIN_LOW, 16'h0000, 16'hffc5, 1'b1);
      acc(1'b1, CMD_MARGIN_LOW, 16'h0010, 16'h0000, 1'b1);
      acc(1'b0, CMD_MARGIN_LOW, 16'h0000, 16'hffff, 1'b1);
      chk(16'({invalid_data_fault, comm_fault_summary, alert_n}),
         16'h0006);
      pulse(fault_clear);
      acc(1'b1, CMD_MARGIN_LOW, 16'hff00, 16'h0000, 1'b1);
      acc(1'b0, CMD_MARGIN_LOW, 16'h0000, 16'hffc0, 1'b1);
      pulse(fault_clear);
      acc(1'b1, CMD_PCT_LIMIT, 16'h00ff, 16'h0000, 1'b1);
      acc(1'b0, CMD_PCT_LIMIT, 16'h0000, 16'h0003, 1'b1);
      loop_slave = 1'b1;
      acc(1'b0, CMD_MARGIN_LOW, 16'h0000, 16'h0000, 1'b0);
      acc(1'b1, CMD_PCT_LIMIT, 16'h0001, 16'h0000, 1'b0);
      chk(16'({invalid_command_fault, alert_n}), 16'h0002);
      loop_slave = 1'b0;
      acc(1'b0, CMD_PCT_LIMIT, 16'h0000, 16'h0003, 1'b1);
      acc(1'b0, 8'h00, 16'h0000, 16'h0000, 1'b0);
      pulse(fault_clear);
      $display("test access done");
      pg(100, 1'b1);
      for (int s = 0; s < 4; s++) begin
         acc(1'b1, CMD_PCT_LIMIT, 16'(s), 16'h0000, 1'b1);
         pg(ov[s] - 1, 1'b1);
         pg(ov[s] + 1, 1'b0);
         pg(ov[s] - 2, 1'b0);
         pg(104, 1'b1);
         pg(uv[s] + 1, 1'b1);
         pg(uv[s] - 1, 1'b0);
         pg(uv[s] + 2, 1'b0);
         pg(96, 1'b1);
      end
      margin_low_op = 1'b1;
      repeat (4) @(negedge clk_sys);
      chk(error_amp_reference, 16'h01c0);
      vout_min = 16'h01e0;
      repeat (4) @(negedge clk_sys);
      chk(error_amp_reference, 16'h01e0);
      {power_state, rate_rise, vout_min} = {2'd0, 16'h0010, 16'h0000};
      @(negedge clk_sys);
      chk(error_amp_reference, 16'h01d0);
      $display("test power good done");
      acc(1'b1, CMD_USER_OPTIONS, 16'he00f, 16'h0000, 1'b1);
      chk(16'({fast_vout_measure, adc_enable_bit,
         neg_current_limit_disable}), 16'h0007);
      chk(margin_high_restore, 16'h000f);
      chk(16'({power_good_out, reset_pin_n}), 16'h0003);
      @(negedge clk_sys);
      chk(16'(fast_mode_changed), 16'h0001);
      acc(1'b0, CMD_USER_OPTIONS, 16'h0000, 16'h600f, 1'b1);
      pulse(store_req);
      chk(16'(nv_write), 16'h0001);
      chk(nv_options, 16'h6007);
      nv_options_in = 16'h200d;
      pulse(restore_req);
      acc(1'b0, CMD_USER_OPTIONS, 16'h0000, 16'h2005, 1'b1);
      acc(1'b0, CMD_MARGIN_LOW, 16'h0000, 16'hfff1, 1'b1);
      chk(margin_high_restore, 16'h0009);
      $display("test options done");
      summarize();
   end
endmodule : pmr_regs_test
